// >>> lcdsd_top.sv
// Purpose: Segment display driver with AHB-Lite register and memory access.
// Assumes: osc_tick is a one-cycle pulse per slow-oscillator period, far
//   slower than 41 clocks; bus is zero wait state.
// Notes: Outputs are digital phase levels; analogue bias is outside.
`timescale 1ns/1ns
// Operation
// - Four or five commons per frame, three-level bias, selected by software.
// - Five commons, forty segments; segment forty becomes common five.
// - Memory is scanned by hardware while the processor reads and writes it.
// - Display runs in STOP whenever the slow oscillator is enabled.
// - Pump off leaves every stored nibble untouched.
// - Display disabled drives every common and segment low.
// - Display memory acts as plain data memory when display is off.
// - Four-common: segment n reads nibble n-1, bits map commons one-four.
// - Five-common: common five uses bit0 of second block.
// - Pump control bit3 turns pump on, resets cleared.
// - System register bit2 enables display, resets cleared.
// - Pump clock fixed, independent of oscillator type.
// - Frame is oscillator over 384x2 or 400x2.
// - Pump off forces every common and segment to ground despite display enable.
// - Oscillator enable bit: 0 off, 1 on, resets 0.
// - Oscillator enable at bit3, heavy load at bit2.
module lcdsd_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic osc_tick,
  input wire logic bond_option_hi,
  input wire logic bond_option_lo,
  output logic slow_osc_enable,
  output logic crystal_heavy_load,
  output logic pullup_global_enable,
  output logic pump_enable,
  output logic pump_clk,
  output logic [4:0] common_line,
  output logic [39:0] segment_line
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic display_enable;
  lcdsd_pkg::lcdsd_duty_t duty;
  logic accept;
  logic [9:0] a_idx;
  logic a_hit;
  logic dp_wr;
  logic [9:0] dp_idx;
  logic [3:0] wnib;
  logic next_pump;
  logic next_osc;
  logic next_heavy;
  logic next_pull;
  logic next_disp;
  logic next_duty;
  logic ram_wr;
  logic [6:0] ram_waddr;
  logic [6:0] ram_raddr;
  logic [3:0] ram_rdata;
  logic [3:0] rd_nib;
  logic tick;
  logic [2:0] com_idx;
  logic [2:0] next_idx;
  logic polarity;
  logic slot_start;
  logic [5:0] fcnt;
  logic [5:0] fcnt_q;
  logic [2:0] fidx_q;
  logic [39:0] shadow;
  logic [39:0] seg_hold;
  logic active;
  logic [4:0] com_sel;

  lcdsd_fetch_if fetch ();

  // ---------------------------------------------------------------
  // Bus address phase decode
  // ---------------------------------------------------------------
  assign accept = hsel && hready && htrans == lcdsd_pkg::HTRANS_NONSEQ;
  assign a_idx = haddr[11:2];
  assign a_hit = haddr[31:12] == 20'h00000 && haddr[1:0] == 2'h0;
  assign wnib = hwdata[3:0];

  // Data phase capture for writes
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dp_wr <= 1'b0;
      dp_idx <= 10'h000;
    end else begin
      dp_wr <= accept && hwrite && a_hit;
      dp_idx <= a_idx;
    end
  end

  // Zero wait state, always OKAY
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Control registers, with write data applied ahead of storage
  // ---------------------------------------------------------------
  always_comb begin
    next_pump = pump_enable;
    next_osc = slow_osc_enable;
    next_heavy = crystal_heavy_load;
    next_pull = pullup_global_enable;
    next_disp = display_enable;
    next_duty = duty;
    if (dp_wr) begin
      unique case (dp_idx)
        lcdsd_pkg::IDX_PUMP: next_pump = wnib[lcdsd_pkg::PUMP_ON_BIT];
        lcdsd_pkg::IDX_OSC: begin
          next_osc = wnib[lcdsd_pkg::OSC_EN_BIT];
          next_heavy = wnib[lcdsd_pkg::HEAVY_BIT];
        end
        lcdsd_pkg::IDX_SYS: begin
          next_pull = wnib[lcdsd_pkg::PULL_BIT];
          next_disp = wnib[lcdsd_pkg::DISP_BIT];
        end
        lcdsd_pkg::IDX_MODE: next_duty = wnib[lcdsd_pkg::DUTY_BIT];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pump_enable <= lcdsd_pkg::RST_BIT;
    end else begin
      pump_enable <= next_pump;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slow_osc_enable <= lcdsd_pkg::RST_BIT;
      crystal_heavy_load <= lcdsd_pkg::RST_BIT;
    end else begin
      slow_osc_enable <= next_osc;
      crystal_heavy_load <= next_heavy;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      display_enable <= lcdsd_pkg::RST_BIT;
      pullup_global_enable <= lcdsd_pkg::RST_BIT;
    end else begin
      display_enable <= next_disp;
      pullup_global_enable <= next_pull;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      duty <= lcdsd_pkg::LCDSD_DUTY4;
    end else begin
      duty <= lcdsd_pkg::lcdsd_duty_t'(next_duty);
    end
  end

  // ---------------------------------------------------------------
  // Display memory, processor side
  // ---------------------------------------------------------------
  // memory open regardless of pump and display
  assign ram_wr = dp_wr && dp_idx >= lcdsd_pkg::IDX_RAM_LO && dp_idx <= lcdsd_pkg::IDX_RAM_HI;
  assign ram_waddr = 7'(dp_idx - lcdsd_pkg::IDX_RAM_LO);
  assign ram_raddr = 7'(a_idx - lcdsd_pkg::IDX_RAM_LO);
  // Forward a write still in its data phase
  assign rd_nib = (ram_wr && ram_waddr == ram_raddr) ? wnib : ram_rdata;

  lcdsd_ram #(.WORDS(lcdsd_pkg::RAM_WORDS)) u_ram (
    .clock(clock),
    .wr_en(ram_wr),
    .wr_addr(ram_waddr),
    .wr_data(wnib),
    .rd_addr(ram_raddr),
    .rd_data(ram_rdata),
    .fetch(fetch)
  );

  // Read data captured at the address phase edge, unmapped reads zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (accept && !hwrite) begin
      hrdata <= 32'h00000000;
      if (a_hit) begin
        if (a_idx == lcdsd_pkg::IDX_PUMP) begin
          hrdata[lcdsd_pkg::PUMP_ON_BIT] <= next_pump;
        end else if (a_idx == lcdsd_pkg::IDX_OSC) begin
          hrdata[lcdsd_pkg::OSC_EN_BIT] <= next_osc;
          hrdata[lcdsd_pkg::HEAVY_BIT] <= next_heavy;
        end else if (a_idx == lcdsd_pkg::IDX_SYS) begin
          hrdata[lcdsd_pkg::PULL_BIT] <= next_pull;
          hrdata[lcdsd_pkg::DISP_BIT] <= next_disp;
          hrdata[lcdsd_pkg::BOND_HI_BIT] <= bond_option_hi;
          hrdata[lcdsd_pkg::BOND_LO_BIT] <= bond_option_lo;
        end else if (a_idx == lcdsd_pkg::IDX_MODE) begin
          hrdata[lcdsd_pkg::DUTY_BIT] <= next_duty;
        end else if (a_idx >= lcdsd_pkg::IDX_RAM_LO && a_idx <= lcdsd_pkg::IDX_RAM_HI) begin
          hrdata[3:0] <= rd_nib;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Scan timing
  // ---------------------------------------------------------------
  // runs on the slow oscillator alone, core state ignored
  assign tick = osc_tick && slow_osc_enable;

  lcdsd_timing #(
    .DIV4(lcdsd_pkg::FRAME_DIV4),
    .DIV5(lcdsd_pkg::FRAME_DIV5),
    .PTICKS(lcdsd_pkg::PUMP_TICKS)
  ) u_timing (
    .clock(clock),
    .rst_n(rst_n),
    .tick(tick),
    .duty(duty),
    .com_idx(com_idx),
    .next_idx(next_idx),
    .polarity(polarity),
    .slot_start(slot_start),
    .pump_clk(pump_clk)
  );

  // ---------------------------------------------------------------
  // Scanner fetch of the next common's segment bits
  // ---------------------------------------------------------------
  // nibble address per segment
  assign fetch.addr = (next_idx == 3'h4) ? lcdsd_pkg::COMMON_LINE_5_BASE + 7'(fcnt) : 7'(fcnt);

  // Segment walk, one nibble per clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fcnt <= 6'h00;
      fcnt_q <= 6'h00;
      fidx_q <= 3'h0;
    end else begin
      fcnt <= (fcnt == 6'(lcdsd_pkg::NUM_SEG - 1)) ? 6'h00 : fcnt + 6'h01;
      fcnt_q <= fcnt;
      fidx_q <= next_idx;
    end
  end

  // pick the bit for this common
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shadow <= 40'h0000000000;
    end else if (fidx_q == 3'h4) begin
      shadow[fcnt_q] <= fetch.data[0];
    end else begin
      shadow[fcnt_q] <= fetch.data[fidx_q[1:0]];
    end
  end

  // Latch the fetched row as a slot begins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      seg_hold <= 40'h0000000000;
    end else if (slot_start) begin
      seg_hold <= shadow;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  // both enables needed
  assign active = display_enable && pump_enable;
  assign com_sel = 5'h01 << com_idx;

  // segment forty doubles as common five
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      common_line <= 5'h00;
      segment_line <= 40'h0000000000;
    end else if (!active) begin
      common_line <= 5'h00;
      segment_line <= 40'h0000000000;
    end else if (duty == lcdsd_pkg::LCDSD_DUTY5) begin
      common_line <= com_sel ^ {5{polarity}};
      segment_line <= {com_sel[4] ^ polarity, seg_hold[38:0] ^ {39{polarity}}};
    end else begin
      common_line <= {1'b0, com_sel[3:0] ^ {4{polarity}}};
      segment_line <= seg_hold ^ {40{polarity}};
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // display off means low pins
  disp_off_low_a: assert property (@(posedge clock) disable iff (!rst_n)
    !display_enable |=> common_line == 5'h00 && segment_line == 40'h0000000000)
    else $error("pins not low with display off");
  pump_off_low_a: assert property (@(posedge clock) disable iff (!rst_n)
    !pump_enable |=> common_line == 5'h00 && segment_line == 40'h0000000000)
    else $error("pins not low with pump off");
  pump_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    dp_wr && dp_idx == lcdsd_pkg::IDX_PUMP |=> pump_enable == $past(hwdata[3]))
    else $error("pump bit not written");
  disp_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    dp_wr && dp_idx == lcdsd_pkg::IDX_SYS |=> display_enable == $past(hwdata[2]))
    else $error("display bit not written");
  osc_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    dp_wr && dp_idx == lcdsd_pkg::IDX_OSC
    |=> slow_osc_enable == $past(hwdata[3]) && crystal_heavy_load == $past(hwdata[2]))
    else $error("oscillator fields not written");
  common_line_5_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
    duty == lcdsd_pkg::LCDSD_DUTY4 |=> !common_line[4])
    else $error("common five driven in four-common mode");
endmodule : lcdsd_top

// >>> lcdsd_pkg.sv
// Purpose: Shared constants and types for the segment display driver.
// Assumes: Registers are 4-bit wide, one per aligned 32-bit word.
// Notes: Byte address of each register is four times its index.
package lcdsd_pkg;
  // ---------------------------------------------------------------
  // Register indexes
  // ---------------------------------------------------------------
  localparam logic [9:0] IDX_PUMP = 10'h002;
  localparam logic [9:0] IDX_OSC = 10'h004;
  localparam logic [9:0] IDX_SYS = 10'h013;
  localparam logic [9:0] IDX_MODE = 10'h020;
  localparam logic [9:0] IDX_RAM_LO = 10'h300;
  localparam logic [9:0] IDX_RAM_HI = 10'h35F;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int PUMP_ON_BIT = 3;
  localparam int OSC_EN_BIT = 3;
  localparam int HEAVY_BIT = 2;
  localparam int PULL_BIT = 3;
  localparam int DISP_BIT = 2;
  localparam int BOND_HI_BIT = 1;
  localparam int BOND_LO_BIT = 0;
  localparam int DUTY_BIT = 0;
  localparam logic RST_BIT = 1'b0;
  // ---------------------------------------------------------------
  // Display geometry and timing
  // ---------------------------------------------------------------
  localparam int RAM_WORDS = 96;
  localparam int NUM_SEG = 40;
  localparam int NUM_COM = 5;
  localparam logic [6:0] COMMON_LINE_5_BASE = 7'h30;
  localparam int FRAME_DIV4 = 384;
  localparam int FRAME_DIV5 = 400;
  localparam int SLOW_OSC_HZ = 32768;
  localparam int PUMP_HZ = 4096;
  localparam int PUMP_TICKS = SLOW_OSC_HZ / PUMP_HZ;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // Duty selection
  typedef enum logic {
    LCDSD_DUTY4 = 1'b0,
    LCDSD_DUTY5 = 1'b1
  } lcdsd_duty_t;
endpackage : lcdsd_pkg

// >>> lcdsd_fetch_if.sv
// Purpose: Scanner read port between display memory and the driver.
// Assumes: One nibble read per clock, result one clock later.
// Notes: Read-only path; processor writes use their own port.
`timescale 1ns/1ns
interface lcdsd_fetch_if;
  logic [6:0] addr;
  logic [3:0] data;
  modport ram (input addr, output data);
  modport scan (output addr, input data);
endinterface : lcdsd_fetch_if

// >>> lcdsd_ram.sv
// Purpose: Dual-ported display nibble memory.
// Assumes: Write and processor read take separate addresses from the bus side.
// Notes: Contents are not reset, like ordinary data memory.
`timescale 1ns/1ns
module lcdsd_ram #(
  parameter int WORDS = lcdsd_pkg::RAM_WORDS
) (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [6:0] wr_addr,
  input wire logic [3:0] wr_data,
  input wire logic [6:0] rd_addr,
  output logic [3:0] rd_data,
  lcdsd_fetch_if.ram fetch
);
  logic [3:0] mem [WORDS];

  // Processor write port, never touched by the scanner
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Processor read, combinational
  assign rd_data = mem[rd_addr];

  always_ff @(posedge clock) begin
    fetch.data <= mem[fetch.addr];
  end

  ram_store_a: assert property (@(posedge clock) wr_en |=>
    mem[$past(wr_addr)] == $past(wr_data)) else $error("ram write lost");
endmodule : lcdsd_ram

// >>> lcdsd_timing.sv
// Purpose: Common slot sequencer and pump clock divider.
// Assumes: tick is a one-cycle pulse per slow-oscillator period.
// Notes: A frame is two phases of opposite polarity.
`timescale 1ns/1ns
module lcdsd_timing #(
  parameter int DIV4 = lcdsd_pkg::FRAME_DIV4,
  parameter int DIV5 = lcdsd_pkg::FRAME_DIV5,
  parameter int PTICKS = lcdsd_pkg::PUMP_TICKS
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tick,
  input wire lcdsd_pkg::lcdsd_duty_t duty,
  output logic [2:0] com_idx,
  output logic [2:0] next_idx,
  output logic polarity,
  output logic slot_start,
  output logic pump_clk
);
  logic [8:0] slot_len;
  logic [8:0] cnt;
  logic [2:0] last;
  logic [3:0] pcnt;

  assign slot_len = (duty == lcdsd_pkg::LCDSD_DUTY5) ? 9'(DIV5 / 5) : 9'(DIV4 / 4);
  assign last = (duty == lcdsd_pkg::LCDSD_DUTY5) ? 3'h4 : 3'h3;
  assign next_idx = (com_idx >= last) ? 3'h0 : com_idx + 3'h1;

  // Last tick of a slot, so the row latches together with the common step
  assign slot_start = tick && cnt >= slot_len - 9'h001;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 9'h000;
      com_idx <= 3'h0;
      polarity <= 1'b0;
    end else begin
      if (tick) begin
        if (cnt >= slot_len - 9'h001) begin
          cnt <= 9'h000;
          com_idx <= next_idx;
          if (com_idx >= last) begin
            polarity <= ~polarity;
          end
        end else begin
          cnt <= cnt + 9'h001;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pcnt <= 4'h0;
      pump_clk <= 1'b0;
    end else if (tick) begin
      if (pcnt == 4'(PTICKS / 2 - 1)) begin
        pcnt <= 4'h0;
        pump_clk <= ~pump_clk;
      end else begin
        pcnt <= pcnt + 4'h1;
      end
    end
  end

  com_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    !(tick && cnt >= slot_len - 9'h001) |=> $stable(com_idx))
    else $error("common moved mid-slot");
  sequence slot_end_s;
    tick && cnt >= slot_len - 9'h001;
  endsequence
  // each slot end steps to the next common
  com_step_a: assert property (@(posedge clock) disable iff (!rst_n)
    slot_end_s |=> com_idx == $past(next_idx))
    else $error("common did not step");
  wrap_pol_a: assert property (@(posedge clock) disable iff (!rst_n)
    slot_end_s ##0 com_idx >= last
    |=> com_idx == 3'h0 && polarity != $past(polarity))
    else $error("frame wrap wrong");
  // pump clock moves on ticks only
  pump_tick_a: assert property (@(posedge clock) disable iff (!rst_n)
    !tick |=> $stable(pump_clk)) else $error("pump clock moved without tick");
endmodule : lcdsd_timing

// >>> lcdsd_panel.sv
// Purpose: Glass panel model decoding the common and segment drive.
// Assumes: Pins settle within two clocks of a change on the commons.
// Notes: Reports lit common, drive polarity and plain segment data.
`timescale 1ns/1ns
module lcdsd_panel (
  input wire logic clock,
  input wire logic [4:0] common_line,
  input wire logic [39:0] segment_line,
  input wire logic five_com,
  output logic upd,
  output logic pol,
  output logic [2:0] idx,
  output logic [39:0] seg
);
  logic [4:0] com;
  logic [4:0] prev;
  logic d1;
  logic d2;
  // Segment forty doubles as common five
  assign com = {five_com ? segment_line[39] : 1'b0, common_line[3:0]};
  // Unselected commons carry the polarity level
  always_comb begin
    pol = (com[0] == com[1]) ? com[0] : com[2];
    idx = 3'h0;
    for (int i = 4; i >= 0; i--) begin
      if ((i < 4 || five_com) && com[i] != pol) begin
        idx = 3'(i + 1);
      end
    end
    seg = segment_line ^ {40{pol}};
    if (five_com) begin
      seg[39] = 1'b0;
    end
  end
  // Report two clocks after the commons move
  always_ff @(posedge clock) begin
    prev <= com;
    d1 <= (com != prev);
    d2 <= d1;
  end
  assign upd = d2 && (idx != 3'h0);
endmodule : lcdsd_panel

// >>> lcdsd_top_tb.sv
// Purpose: Self-checking bench for the segment display driver.
// Assumes: Zero-wait bus; slow-oscillator tick every second clock.
// Notes: Panel reports are checked against a queue of expected slots.
`timescale 1ns/1ns
module lcdsd_top_tb;
  logic clock;
  logic rst_n;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic osc_tick;
  logic slow_osc_enable;
  logic crystal_heavy_load;
  logic pullup_global_enable;
  logic pump_enable;
  logic pump_clk;
  logic [4:0] common_line;
  logic [39:0] segment_line;
  logic five_com;
  logic upd;
  logic pol;
  logic [2:0] idx;
  logic [39:0] seg;
  logic tick_on;
  logic [3:0] ram [96];
  logic [43:0] expq [$];
  logic [31:0] rnd;
  logic [31:0] rd;
  int err_total;
  int checks;
  int skip;
  int cycles;
  int lastc;
  int pcyc;
  logic pclk_q;

  lcdsd_top dut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .osc_tick(osc_tick),
    .bond_option_hi(1'b1), .bond_option_lo(1'b0), .slow_osc_enable(slow_osc_enable),
    .crystal_heavy_load(crystal_heavy_load), .pullup_global_enable(pullup_global_enable),
    .pump_enable(pump_enable), .pump_clk(pump_clk), .common_line(common_line),
    .segment_line(segment_line));
  lcdsd_panel glass (.clock(clock), .common_line(common_line), .segment_line(segment_line),
    .five_com(five_com), .upd(upd), .pol(pol), .idx(idx), .seg(seg));

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction : xs

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One single transfer; entered just after a rising edge
  task automatic bus(input logic wr, input logic [9:0] i, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {20'h0, i, 2'h0};
    htrans <= lcdsd_pkg::HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
    chk("bus response", 48'h0, 48'(hresp));
  endtask : bus

  task automatic rchk(input string nm, input logic [9:0] i, input logic [3:0] e);
    bus(1'b0, i, 32'h0);
    chk(nm, 48'(e), 48'(rd));
  endtask : rchk

  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic fill();
    for (int k = 0; k < 96; k++) begin
      rnd = xs(rnd);
      ram[k] = rnd[3:0];
      bus(1'b1, 10'h300 + 10'(k), rnd);
    end
  endtask : fill

  // Power-up flow, then one whole frame of slots while memory is read
  task automatic bring_up(input int ncom);
    logic [39:0] b;
    int c;
    five_com = (ncom == 5);
    bus(1'b1, lcdsd_pkg::IDX_MODE, 32'(five_com));
    bus(1'b1, lcdsd_pkg::IDX_OSC, 32'h8);
    repeat (20) @(posedge clock);
    bus(1'b1, lcdsd_pkg::IDX_PUMP, 32'h8);
    repeat (20) @(posedge clock);
    for (int k = 1; k <= 2 * ncom; k++) begin
      c = k % ncom;
      for (int n = 0; n < 40; n++) begin
        b[n] = (c < 4) ? ram[n][c] : ram[48 + n][0];
      end
      if (ncom == 5) b[39] = 1'b0;
      expq.push_back({1'(k / ncom), 3'(c + 1), b});
    end
    skip = 1;
    bus(1'b1, lcdsd_pkg::IDX_SYS, 32'h4);
    tick_on <= 1'b1;
    while (expq.size() != 0) begin
      rnd = xs(rnd);
      rchk("scan ram", 10'h300 + 10'(rnd % 96), ram[rnd % 96]);
    end
    tick_on <= 1'b0;
    $display("frame test with %0d commons done", ncom);
  endtask : bring_up

  // Slow-oscillator ticks, one clock high in every two
  always @(posedge clock) begin
    osc_tick <= tick_on ? ~osc_tick : 1'b0;
  end

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Compare each panel report after the first with the oldest expected slot
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      report_and_stop();
    end
    if (upd === 1'b1) begin
      if (skip != 0) begin
        skip = 0;
        lastc = 0;
      end else if (expq.size() == 0) begin
        chk("unexpected slot", 48'h0, {pol, idx, seg});
      end else begin
        if (lastc != 0) chk("slot length",
          five_com ? 2 * lcdsd_pkg::FRAME_DIV5 / 5 : 2 * lcdsd_pkg::FRAME_DIV4 / 4,
          48'(cycles - lastc));
        lastc = cycles;
        chk("slot", expq.pop_front(), {pol, idx, seg});
      end
    end
    // Pump clock half period, two clocks per tick
    if (pump_clk !== pclk_q && pcyc != 0) begin
      chk("pump half period", 48'(lcdsd_pkg::PUMP_TICKS / 2 * 2), 48'(cycles - pcyc));
    end
    if (pump_clk !== pclk_q) pcyc = cycles;
    if (tick_on !== 1'b1 || slow_osc_enable !== 1'b1) pcyc = 0;
    pclk_q = pump_clk;
  end

  initial begin
    logic [9:0] ri [3];
    logic [3:0] rm [3];
    logic [3:0] ro [3];
    ri = '{lcdsd_pkg::IDX_PUMP, lcdsd_pkg::IDX_OSC, lcdsd_pkg::IDX_SYS};
    rm = '{4'h8, 4'hC, 4'hE};
    ro = '{4'h1, 4'hC, 4'h2};
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    tick_on = 1'b0;
    osc_tick = 1'b0;
    five_com = 1'b0;
    rnd = 32'h2;
    do_reset();
    for (int r = 0; r < 3; r++) begin
      rchk("reset value", ri[r], (r == 2) ? 4'h2 : 4'h0);
      bus(1'b1, ri[r], 32'hF);
      rchk("written value", ri[r], rm[r]);
      chk("control pins", 48'(ro[r]),
        {slow_osc_enable, crystal_heavy_load, pullup_global_enable, pump_enable});
      bus(1'b1, ri[r], 32'h0);
    end
    rchk("mode reset", lcdsd_pkg::IDX_MODE, 4'h0);
    bus(1'b1, 10'h03F, 32'hF);
    rchk("unmapped", 10'h03F, 4'h0);
    $display("register test done");
    fill();
    bring_up(4);
    bus(1'b1, lcdsd_pkg::IDX_OSC, 32'h0);
    tick_on <= 1'b1;
    repeat (400) @(posedge clock);
    tick_on <= 1'b0;
    bus(1'b1, lcdsd_pkg::IDX_PUMP, 32'h0);
    repeat (3) @(posedge clock);
    chk("pins pump off", 48'h0, {common_line, segment_line});
    bus(1'b1, lcdsd_pkg::IDX_SYS, 32'h0);
    bus(1'b1, lcdsd_pkg::IDX_PUMP, 32'h8);
    repeat (3) @(posedge clock);
    chk("pins display off", 48'h0, {common_line, segment_line});
    for (int k = 0; k < 96; k++) begin
      rchk("ram kept", 10'h300 + 10'(k), ram[k]);
    end
    fill();
    for (int k = 0; k < 96; k += 7) begin
      rchk("ram as data", 10'h300 + 10'(k), ram[k]);
    end
    $display("gating and memory test done");
    do_reset();
    rchk("pump after reset", lcdsd_pkg::IDX_PUMP, 4'h0);
    fill();
    bring_up(5);
    report_and_stop();
  end
endmodule : lcdsd_top_tb
